/* File: leak_detector.sv */
// Leak decision logic: differential-flow queues per pipeline and
// over-velocity counters per section, with an APB register slave.
// Assumes measurement inputs are synchronous to pclk and stable while
// meas_strobe pulses once per measurement cycle.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Skip flow comparison when any end flow is bad, unless override on.
// - Override forces comparison despite hardware faults; it resets off.
// - Averaged difference versus alarm threshold, reset zero, drives alarm relay.
// - Averaged difference versus warning threshold, reset zero, drives warning relay.
// - New differences append to the queue until it holds the size, reset 25.
// - A full queue overwrites its oldest entry.
// - Queue entries are all zero after startup.
// - Nothing is calculated unless the global enable is on; it resets off.
// - Each pipeline has its own enable, reset off; both must be on.
// - One average of good path velocities per section feeds every threshold.
// - Positive counter goes up above its threshold, otherwise down.
// - Alarm relay closes when the alarm counter reaches the alarm count.
// - Warning counters use warning thresholds and the warning count, reset 25.
// - Negative counters run in parallel against negative thresholds.
// - Alarm thresholds reset to plus and minus 150% of maximum velocity.
// - Warning thresholds reset to plus and minus maximum velocity.
// - Velocity settings per section; queue and difference settings per pipeline.
// - No over-velocity counter goes below zero.
// - Average is queue sum over full configured size, even when not full.
// - Relays do not latch; they follow their condition.
// - With all flows good, the signed end difference is enqueued.
module leak_detector
	import leak_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic meas_strobe,
	input wire logic hw_fault,
	input wire sec_meas_type [NUM_SEC-1:0] sec_meas,
	input wire pipe_flow_type [NUM_PIPE-1:0] pipe_flow,
	output logic [NUM_PIPE-1:0] diff_warn_relay,
	output logic [NUM_PIPE-1:0] diff_alarm_relay,
	output sec_relay_type [NUM_SEC-1:0] ov_relay
);

	// Velocity threshold times path count, so no divider is needed
	function automatic logic signed [19:0] scale(input logic signed [15:0] t,
		input logic [2:0] n);
		logic signed [19:0] te;
		logic signed [19:0] ne;
		te = 20'(t);
		ne = signed'({17'h0_0000, n});
		scale = 20'(te * ne);
	endfunction

	// Control state, per-pipeline and per-section settings, queue sums
	logic global_en;
	logic override;
	pipe_cfg_type [NUM_PIPE-1:0] pipe_cfg;
	sec_cfg_type [NUM_SEC-1:0] sec_cfg;
	logic signed [SUM_W-1:0] qsum [NUM_PIPE];
	logic [NUM_SEC-1:0][4*CNT_W-1:0] sec_counts;

	// APB phases: setup samples the read, access (pready high) commits
	wire setup = psel & ~penable;
	wire commit = psel & penable & pready;
	wire wr_commit = commit & pwrite;

	// Address decode
	wire is_ctrl = (paddr == CTRL_ADDR);
	wire is_stat = (paddr == STAT_ADDR);
	wire [3:0] region = paddr[11:8];
	wire [3:0] pipe_idx = paddr[7:4];
	wire [1:0] pipe_word = paddr[3:2];
	wire [2:0] sec_idx = paddr[7:5];
	wire [2:0] sec_word = paddr[4:2];
	wire aligned = (paddr[1:0] == 2'b00);
	wire is_pipe = aligned & (region == PIPE_REGION) & (32'(pipe_idx) < NUM_PIPE);
	wire is_sec = aligned & (region == SEC_REGION) & (32'(sec_idx) < NUM_SEC)
		& (sec_word != 3'h7);
	wire mapped = is_ctrl | is_stat | is_pipe | is_sec;
	wire [0:0] pipe_sel = pipe_idx[0:0];
	wire [1:0] sec_sel = sec_idx[1:0];

	// Status word: relay states, hardware fault and enables
	wire [31:0] stat_word = {9'h000, hw_fault, override, global_en,
		ov_relay, diff_alarm_relay, diff_warn_relay};

	// Read selection
	wire [31:0] ctrl_rd = {30'h0000_0000, override, global_en};
	wire [31:0] pipe_ctrl_rd = {18'h0_0000, pipe_cfg[pipe_sel].qsize, 7'h00,
		pipe_cfg[pipe_sel].enable};
	wire [31:0] pipe_rd = (pipe_word == PIPE_CTRL_WORD) ? pipe_ctrl_rd
		: (pipe_word == PIPE_WARN_WORD) ? {16'h0000, pipe_cfg[pipe_sel].warn_thr}
		: (pipe_word == PIPE_ALARM_WORD) ? {16'h0000, pipe_cfg[pipe_sel].alarm_thr}
		: 32'(qsum[pipe_sel]);
	wire [31:0] sec_rd = (sec_word == SEC_PWARN_WORD) ? 32'(sec_cfg[sec_sel].pos_warn)
		: (sec_word == SEC_NWARN_WORD) ? 32'(sec_cfg[sec_sel].neg_warn)
		: (sec_word == SEC_PALARM_WORD) ? 32'(sec_cfg[sec_sel].pos_alarm)
		: (sec_word == SEC_NALARM_WORD) ? 32'(sec_cfg[sec_sel].neg_alarm)
		: (sec_word == SEC_WCOUNT_WORD) ? {24'h00_0000, sec_cfg[sec_sel].warn_count}
		: (sec_word == SEC_ACOUNT_WORD) ? {24'h00_0000, sec_cfg[sec_sel].alarm_count}
		: sec_counts[sec_sel];
	wire [31:0] rd_word = is_ctrl ? ctrl_rd : is_stat ? stat_word
		: is_pipe ? pipe_rd : is_sec ? sec_rd : 32'h0000_0000;

	// Bus answer: one wait-free access phase, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// Global control word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			global_en <= 1'b0;
			override <= 1'b0;
		end
		else if (wr_commit & is_ctrl)
		begin
			global_en <= pwdata[CTRL_GLOBAL_EN_BIT];
			override <= pwdata[CTRL_OVERRIDE_BIT];
		end
	end

	// Queue size as written, clamped to 1..QUEUE_MAX
	wire [QSIZE_W-1:0] wr_qsize = pwdata[PIPE_QSIZE_LSB +: QSIZE_W];
	wire [QSIZE_W-1:0] clamped_qsize = (wr_qsize == '0) ? QSIZE_W'(1)
		: (32'(wr_qsize) > QUEUE_MAX) ? QSIZE_W'(QUEUE_MAX) : wr_qsize;

	// One bank per pipeline and one per section
	genvar gp;
	genvar gs;

	// Pipeline banks: settings, averaging queue and differential relays
	generate
		for (gp = 0; gp < NUM_PIPE; gp++)
		begin : pipe_bank
			logic signed [DIFF_W-1:0] entry [QUEUE_MAX];
			logic [QPTR_W-1:0] wptr;
			wire bank_wr = wr_commit & is_pipe & (32'(pipe_sel) == gp);
			wire qsize_wr = bank_wr & (pipe_word == PIPE_CTRL_WORD);
			wire run = global_en & pipe_cfg[gp].enable;
			wire flows_good = pipe_flow[gp].up_good & pipe_flow[gp].down_good & ~hw_fault;
			wire compare_ok = flows_good | override;
			wire push = meas_strobe & run & compare_ok;
			wire signed [DIFF_W-1:0] diff = DIFF_W'(pipe_flow[gp].up_flow)
				- DIFF_W'(pipe_flow[gp].down_flow);
			wire signed [DIFF_W-1:0] oldest = entry[wptr];
			wire signed [SUM_W-1:0] next_sum = qsum[gp] + SUM_W'(diff) - SUM_W'(oldest);
			wire last_slot = (32'(wptr) == 32'(pipe_cfg[gp].qsize) - 1);
			wire [QPTR_W-1:0] next_wptr = last_slot ? '0 : QPTR_W'(wptr + 1'b1);
			// Average = sum / size; compare |sum| with threshold * size instead
			wire [SUM_W-1:0] magnitude = qsum[gp][SUM_W-1] ? SUM_W'(-qsum[gp])
				: SUM_W'(qsum[gp]);
			wire [SUM_W-1:0] warn_scaled = SUM_W'(pipe_cfg[gp].warn_thr * pipe_cfg[gp].qsize);
			wire [SUM_W-1:0] alarm_scaled = SUM_W'(pipe_cfg[gp].alarm_thr * pipe_cfg[gp].qsize);
			wire relay_ok = run & (~hw_fault | override);

			// Settings for this pipeline
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pipe_cfg[gp].enable <= 1'b0;
					pipe_cfg[gp].qsize <= QSIZE_RESET;
					pipe_cfg[gp].warn_thr <= DIFF_THR_RESET;
					pipe_cfg[gp].alarm_thr <= DIFF_THR_RESET;
				end
				else if (bank_wr)
				begin
					if (pipe_word == PIPE_CTRL_WORD)
					begin
						pipe_cfg[gp].enable <= pwdata[PIPE_EN_BIT];
						pipe_cfg[gp].qsize <= clamped_qsize;
					end
					if (pipe_word == PIPE_WARN_WORD)
						pipe_cfg[gp].warn_thr <= pwdata[15:0];
					if (pipe_word == PIPE_ALARM_WORD)
						pipe_cfg[gp].alarm_thr <= pwdata[15:0];
				end
			end

			// Circular queue; unused slots stay zero so the sum stays exact
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					for (int i = 0; i < QUEUE_MAX; i++)
						entry[i] <= '0;
					wptr <= '0;
					qsum[gp] <= '0;
				end
				else if (qsize_wr)
				begin
					// A new size restarts averaging from an empty queue
					for (int i = 0; i < QUEUE_MAX; i++)
						entry[i] <= '0;
					wptr <= '0;
					qsum[gp] <= '0;
				end
				else if (push)
				begin
					entry[wptr] <= diff;
					wptr <= next_wptr;
					qsum[gp] <= next_sum;
				end
			end

			// Relays follow the current average every cycle, never latch
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					diff_warn_relay[gp] <= 1'b0;
					diff_alarm_relay[gp] <= 1'b0;
				end
				else
				begin
					diff_warn_relay[gp] <= relay_ok & (magnitude > warn_scaled);
					diff_alarm_relay[gp] <= relay_ok & (magnitude > alarm_scaled);
				end
			end
		end
	endgenerate

	// Section banks: velocity average, four counters and their relays
	generate
		for (gs = 0; gs < NUM_SEC; gs++)
		begin : sec_bank
			// Sum of good velocities and the four counters of this section
			logic signed [19:0] vsum;
			logic [CNT_W-1:0] cnt_pw;
			logic [CNT_W-1:0] cnt_nw;
			logic [CNT_W-1:0] cnt_pa;
			logic [CNT_W-1:0] cnt_na;
			logic trip_pw;
			logic trip_nw;
			logic trip_pa;
			logic trip_na;
			wire bank_wr = wr_commit & is_sec & (32'(sec_sel) == gs);
			wire [2:0] ngood = 3'($countones(sec_meas[gs].good));
			wire run = global_en & pipe_cfg[gs / SEC_PER_PIPE].enable;
			// No good path means no average; counters hold for that cycle
			wire step = meas_strobe & run & (ngood != 3'h0);

			// Sum of good path velocities; compared as average * count
			always_comb
			begin
				vsum = '0;
				for (int k = 0; k < NUM_PATH; k++)
					if (sec_meas[gs].good[k])
						vsum = vsum + 20'(signed'(sec_meas[gs].vel[k]));
			end

			// Strict compare; a sum equal to the scaled threshold is not beyond
			wire above_pw = vsum > scale(sec_cfg[gs].pos_warn, ngood);
			wire below_nw = vsum < scale(sec_cfg[gs].neg_warn, ngood);
			wire above_pa = vsum > scale(sec_cfg[gs].pos_alarm, ngood);
			wire below_na = vsum < scale(sec_cfg[gs].neg_alarm, ngood);

			// Settings for this section
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sec_cfg[gs].pos_warn <= POS_WARN_RESET;
					sec_cfg[gs].neg_warn <= NEG_WARN_RESET;
					sec_cfg[gs].pos_alarm <= POS_ALARM_RESET;
					sec_cfg[gs].neg_alarm <= NEG_ALARM_RESET;
					sec_cfg[gs].warn_count <= WARN_COUNT_RESET;
					sec_cfg[gs].alarm_count <= ALARM_COUNT_RESET;
				end
				else if (bank_wr)
				begin
					if (sec_word == SEC_PWARN_WORD)
						sec_cfg[gs].pos_warn <= pwdata[15:0];
					if (sec_word == SEC_NWARN_WORD)
						sec_cfg[gs].neg_warn <= pwdata[15:0];
					if (sec_word == SEC_PALARM_WORD)
						sec_cfg[gs].pos_alarm <= pwdata[15:0];
					if (sec_word == SEC_NALARM_WORD)
						sec_cfg[gs].neg_alarm <= pwdata[15:0];
					if (sec_word == SEC_WCOUNT_WORD)
						sec_cfg[gs].warn_count <= pwdata[CNT_W-1:0];
					if (sec_word == SEC_ACOUNT_WORD)
						sec_cfg[gs].alarm_count <= pwdata[CNT_W-1:0];
				end
			end

			ov_counter u_pos_warn (
				.pclk(pclk), .presetn(presetn), .step(step), .beyond(above_pw),
				.limit(sec_cfg[gs].warn_count), .count(cnt_pw), .trip(trip_pw)
			);
			ov_counter u_neg_warn (
				.pclk(pclk), .presetn(presetn), .step(step), .beyond(below_nw),
				.limit(sec_cfg[gs].warn_count), .count(cnt_nw), .trip(trip_nw)
			);
			ov_counter u_pos_alarm (
				.pclk(pclk), .presetn(presetn), .step(step), .beyond(above_pa),
				.limit(sec_cfg[gs].alarm_count), .count(cnt_pa), .trip(trip_pa)
			);
			ov_counter u_neg_alarm (
				.pclk(pclk), .presetn(presetn), .step(step), .beyond(below_na),
				.limit(sec_cfg[gs].alarm_count), .count(cnt_na), .trip(trip_na)
			);

			// Counter snapshot for software, pos_warn in the low byte
			assign sec_counts[gs] = {cnt_na, cnt_pa, cnt_nw, cnt_pw};

			// Relays follow the counters; disabled sections keep them open
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ov_relay[gs] <= '0;
				else
					ov_relay[gs] <= {run & trip_pw, run & trip_nw,
						run & trip_pa, run & trip_na};
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: leak_detector_asserts.sv */
// Port checker for leak_detector: APB answer timing, error replies, relay gating.
// Assumes every APB setup cycle is followed by its access cycle.
`timescale 1ns/1ps
`default_nettype none
module leak_detector_asserts
	import leak_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic meas_strobe,
	input wire logic hw_fault,
	input wire sec_meas_type [NUM_SEC-1:0] sec_meas,
	input wire pipe_flow_type [NUM_PIPE-1:0] pipe_flow,
	input wire logic [NUM_PIPE-1:0] diff_warn_relay,
	input wire logic [NUM_PIPE-1:0] diff_alarm_relay,
	input wire sec_relay_type [NUM_SEC-1:0] ov_relay
);
	// Shadow of the control word; relays react to it one edge late
	logic gen_q;
	logic ovr_q;
	wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_ADDR;
	wire logic no_diff = diff_warn_relay == '0 && diff_alarm_relay == '0;

	// Tracks only completed writes, so a refused access leaves it alone
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			gen_q <= 1'b0;
			ovr_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			gen_q <= pwdata[CTRL_GLOBAL_EN_BIT];
			ovr_q <= pwdata[CTRL_OVERRIDE_BIT];
		end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_access: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	a_ready_setup: assert property (psel && !penable |-> !pready)
		else $error("pready high in setup cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access not refused");
	a_err_hole: assert property (pready && paddr == 12'h21C |-> pslverr)
		else $error("unmapped access not refused");
	a_err_alone: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_quiet: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
		else $error("prdata nonzero outside read access");
	a_gate_global: assert property (!gen_q && !$past(gen_q) |-> no_diff && ov_relay == '0)
		else $error("relay closed while detection is off");
	a_fault_block: assert property (hw_fault && $past(hw_fault) && !ovr_q
		&& !$past(ovr_q) |-> no_diff)
		else $error("differential relay closed during fault");
	a_ov_quiet: assert property (!$past(meas_strobe) && !$past(meas_strobe, 2)
		&& !$past(psel) && !$past(psel, 2) |-> $stable(ov_relay))
		else $error("velocity relay moved without a measurement");
endmodule

bind leak_detector leak_detector_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.meas_strobe(meas_strobe), .hw_fault(hw_fault), .sec_meas(sec_meas),
	.pipe_flow(pipe_flow), .diff_warn_relay(diff_warn_relay),
	.diff_alarm_relay(diff_alarm_relay), .ov_relay(ov_relay)
);
`default_nettype wire

/* File: leak_pkg.sv */
// Shared constants, register map and carrier types for the leak detector.
// Assumes one 25 MHz APB clock domain and 16-bit signed measurement words.
package leak_pkg;

	// Sizes of the plant served by one detector
	localparam int NUM_SEC = 4;
	localparam int NUM_PIPE = 2;
	localparam int NUM_PATH = 4;
	localparam int SEC_PER_PIPE = NUM_SEC / NUM_PIPE;
	localparam int QUEUE_MAX = 32;
	localparam int QPTR_W = 5;
	localparam int QSIZE_W = 6;
	localparam int DIFF_W = 17;
	localparam int SUM_W = 22;
	localparam int CNT_W = 8;

	// Clock figures, kept for reference; the block needs no timed waits
	localparam int CLK_PERIOD_NS = 40;

	// Register map: global words, then pipeline and section banks
	localparam logic [11:0] CTRL_ADDR = 12'h0000;
	localparam logic [11:0] STAT_ADDR = 12'h0004;
	localparam logic [3:0] PIPE_REGION = 4'h1;
	localparam logic [3:0] SEC_REGION = 4'h2;
	localparam logic [1:0] PIPE_CTRL_WORD = 2'h0;
	localparam logic [1:0] PIPE_WARN_WORD = 2'h1;
	localparam logic [1:0] PIPE_ALARM_WORD = 2'h2;
	localparam logic [1:0] PIPE_SUM_WORD = 2'h3;
	localparam logic [2:0] SEC_PWARN_WORD = 3'h0;
	localparam logic [2:0] SEC_NWARN_WORD = 3'h1;
	localparam logic [2:0] SEC_PALARM_WORD = 3'h2;
	localparam logic [2:0] SEC_NALARM_WORD = 3'h3;
	localparam logic [2:0] SEC_WCOUNT_WORD = 3'h4;
	localparam logic [2:0] SEC_ACOUNT_WORD = 3'h5;
	localparam logic [2:0] SEC_COUNTERS_WORD = 3'h6;

	// Field positions
	localparam int CTRL_GLOBAL_EN_BIT = 0;
	localparam int CTRL_OVERRIDE_BIT = 1;
	localparam int PIPE_EN_BIT = 0;
	localparam int PIPE_QSIZE_LSB = 8;

	// Values after reset
	localparam logic signed [15:0] MAX_EXPECTED_VEL = 16'sh0100;
	localparam logic signed [15:0] POS_WARN_RESET = MAX_EXPECTED_VEL;
	localparam logic signed [15:0] NEG_WARN_RESET = -MAX_EXPECTED_VEL;
	localparam logic signed [15:0] POS_ALARM_RESET = 16'((MAX_EXPECTED_VEL * 3) / 2);
	localparam logic signed [15:0] NEG_ALARM_RESET = -POS_ALARM_RESET;
	localparam logic [CNT_W-1:0] WARN_COUNT_RESET = 8'h19;
	localparam logic [CNT_W-1:0] ALARM_COUNT_RESET = 8'h19;
	localparam logic [QSIZE_W-1:0] QSIZE_RESET = 6'h19;
	localparam logic [15:0] DIFF_THR_RESET = 16'h0000;

	// Per-section path measurements
	typedef struct packed {
		logic [NUM_PATH-1:0] good;
		logic [NUM_PATH-1:0][15:0] vel;
	} sec_meas_type;

	// Per-pipeline end flows with their average-flow validity
	typedef struct packed {
		logic up_good;
		logic down_good;
		logic signed [15:0] up_flow;
		logic signed [15:0] down_flow;
	} pipe_flow_type;

	// Section configuration
	typedef struct packed {
		logic signed [15:0] pos_warn;
		logic signed [15:0] neg_warn;
		logic signed [15:0] pos_alarm;
		logic signed [15:0] neg_alarm;
		logic [CNT_W-1:0] warn_count;
		logic [CNT_W-1:0] alarm_count;
	} sec_cfg_type;

	// Pipeline configuration
	typedef struct packed {
		logic enable;
		logic [QSIZE_W-1:0] qsize;
		logic [15:0] warn_thr;
		logic [15:0] alarm_thr;
	} pipe_cfg_type;

	// Relay bundle of one section
	typedef struct packed {
		logic pos_warn;
		logic neg_warn;
		logic pos_alarm;
		logic neg_alarm;
	} sec_relay_type;

endpackage

/* File: ov_counter.sv */
// Saturating up/down threshold-crossing counter for one relay of a section.
// Assumes step is a one-cycle pulse per measurement from the parent.
`timescale 1ns/1ps
`default_nettype none
module ov_counter
	import leak_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic step,
	input wire logic beyond,
	input wire logic [CNT_W-1:0] limit,
	output logic [CNT_W-1:0] count,
	output logic trip
);

	logic [CNT_W-1:0] next_count;
	wire at_top = &count;
	wire at_zero = (count == '0);

	// Up while beyond the threshold, down otherwise, floor at zero
	assign next_count = beyond ? (at_top ? count : CNT_W'(count + 1'b1))
		: (at_zero ? count : CNT_W'(count - 1'b1));

	// Triggered once the count reaches the configured value
	assign trip = (count >= limit);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else if (step)
			count <= next_count;
	end

endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for leak_detector: reset values, velocity counters,
// differential queue. Assumes the bound checker is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb
	import leak_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic meas_strobe = 1'b0;
	logic hw_fault = 1'b0;
	sec_meas_type [NUM_SEC-1:0] sec_meas = '0;
	pipe_flow_type [NUM_PIPE-1:0] pipe_flow = '0;
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic [NUM_PIPE-1:0] diff_warn_relay;
	wire logic [NUM_PIPE-1:0] diff_alarm_relay;
	wire sec_relay_type [NUM_SEC-1:0] ov_relay;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;

	leak_detector u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_strobe(meas_strobe), .hw_fault(hw_fault), .sec_meas(sec_meas),
		.pipe_flow(pipe_flow), .diff_warn_relay(diff_warn_relay),
		.diff_alarm_relay(diff_alarm_relay), .ov_relay(ov_relay)
	);

	always #20 pclk = ~pclk;

	task automatic close_out();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; the request holds through the edge that sees pready
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n = n + 1;
		end
		// Read before the design's updates at this edge land
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50)
			chk("pready", 32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic rdchk(input string name, input logic [11:0] addr, input logic [31:0] exp,
		input logic exp_err);
		apb(1'b0, addr, 32'h0000_0000);
		chk(name, exp, rd);
		chk("pslverr", {31'h0, exp_err}, {31'h0, err});
	endtask

	// Pulses spaced one idle cycle apart; relays settle one edge after the last
	task automatic strobe(input int k);
		repeat (k)
		begin
			@(posedge pclk);
			meas_strobe <= 1'b1;
			@(posedge pclk);
			meas_strobe <= 1'b0;
		end
		@(posedge pclk);
		#1;
	endtask

	// Paths 2 and 3 carry a huge bad value that must never reach the average
	task automatic setvel(input logic [3:0] good, input logic [15:0] v);
		@(posedge pclk);
		sec_meas[0] <= {good, 16'h7000, 16'h7000, v, v};
	endtask

	task automatic flow(input logic up_good, input logic [15:0] up, input logic fault);
		@(posedge pclk);
		pipe_flow[0] <= {up_good, 1'b1, up, 16'h0000};
		hw_fault <= fault;
	endtask

	task automatic ovchk(input logic [3:0] exp);
		chk("ov_relay0", {28'h0, exp}, {28'h0, ov_relay[0]});
	endtask

	// Pipeline 1 stays disabled, so its relays must remain open
	task automatic diffchk(input logic w, input logic a);
		chk("diff_relays", {28'h0, 1'b0, w, 1'b0, a}, {28'h0, diff_warn_relay, diff_alarm_relay});
	endtask

	// Sign of the stored difference is a design choice; magnitude is checked
	task automatic sumchk(input logic [31:0] exp);
		apb(1'b0, 12'h10C, 32'h0000_0000);
		chk("queue_sum", exp, rd[31] ? -rd : rd);
	endtask

	task automatic t_reset();
		rdchk("ctrl", CTRL_ADDR, 32'h0000_0000, 1'b0);
		rdchk("status", STAT_ADDR, 32'h0000_0000, 1'b0);
		rdchk("pipe_ctrl", 12'h100, 32'h0000_1900, 1'b0);
		rdchk("warn_thr", 12'h104, 32'h0000_0000, 1'b0);
		rdchk("alarm_thr", 12'h108, 32'h0000_0000, 1'b0);
		rdchk("sum0", 12'h10C, 32'h0000_0000, 1'b0);
		rdchk("pos_warn", 12'h200, 32'h0000_0100, 1'b0);
		rdchk("neg_warn", 12'h204, 32'hFFFF_FF00, 1'b0);
		rdchk("pos_alarm", 12'h208, 32'h0000_0180, 1'b0);
		rdchk("neg_alarm", 12'h20C, 32'hFFFF_FE80, 1'b0);
		rdchk("warn_count", 12'h210, 32'h0000_0019, 1'b0);
		rdchk("alarm_count", 12'h214, 32'h0000_0019, 1'b0);
		rdchk("hole", 12'h21C, 32'h0000_0000, 1'b1);
		rdchk("unaligned", 12'h002, 32'h0000_0000, 1'b1);
	endtask

	task automatic t_ovvel();
		setvel(4'b0011, 16'h0150);
		strobe(1);
		rdchk("cnt_off", 12'h218, 32'h0000_0000, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'h0000_0001);
		apb(1'b1, 12'h100, 32'h0000_1901);
		apb(1'b1, 12'h210, 32'h0000_0003);
		apb(1'b1, 12'h214, 32'h0000_0002);
		strobe(2);
		ovchk(4'b0000);
		rdchk("cnt_up", 12'h218, 32'h0000_0002, 1'b0);
		strobe(1);
		ovchk(4'b1000);
		setvel(4'b0011, 16'h0000);
		strobe(1);
		ovchk(4'b0000);
		strobe(3);
		rdchk("cnt_floor", 12'h218, 32'h0000_0000, 1'b0);
		setvel(4'b0011, 16'hFE00);
		strobe(2);
		ovchk(4'b0001);
		rdchk("cnt_neg", 12'h218, 32'h0200_0200, 1'b0);
		strobe(1);
		ovchk(4'b0101);
		chk("ov_relay_others", 32'h0000_0000, {20'h0, ov_relay[3], ov_relay[2], ov_relay[1]});
		apb(1'b1, CTRL_ADDR, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		#1;
		ovchk(4'b0000);
		apb(1'b1, 12'h100, 32'h0000_1900);
		apb(1'b1, CTRL_ADDR, 32'h0000_0001);
		strobe(1);
		ovchk(4'b0000);
		rdchk("cnt_hold", 12'h218, 32'h0300_0300, 1'b0);
	endtask

	task automatic t_diff();
		setvel(4'b0000, 16'h0000);
		apb(1'b1, 12'h104, 32'h0000_0002);
		apb(1'b1, 12'h108, 32'h0000_0005);
		apb(1'b1, 12'h100, 32'h0000_0401);
		flow(1'b1, 16'h000A, 1'b0);
		strobe(1);
		diffchk(1'b1, 1'b0);
		sumchk(32'h0000_000A);
		strobe(1);
		diffchk(1'b1, 1'b0);
		strobe(1);
		diffchk(1'b1, 1'b1);
		strobe(1);
		sumchk(32'h0000_0028);
		flow(1'b1, 16'h0000, 1'b0);
		strobe(1);
		sumchk(32'h0000_001E);
		flow(1'b0, 16'h0050, 1'b0);
		strobe(1);
		sumchk(32'h0000_001E);
		flow(1'b1, 16'h0000, 1'b1);
		strobe(1);
		diffchk(1'b0, 1'b0);
		sumchk(32'h0000_001E);
		// Fault and enable bits, section 0 relays held from its counters
		rdchk("status_fault", STAT_ADDR, 32'h0050_0050, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'h0000_0003);
		strobe(1);
		diffchk(1'b1, 1'b0);
		sumchk(32'h0000_0014);
		flow(1'b1, 16'h0000, 1'b0);
		apb(1'b1, 12'h100, 32'h0000_0400);
		strobe(1);
		diffchk(1'b0, 1'b0);
	endtask

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			mismatches = mismatches + 1;
			close_out();
		end
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ovvel();
		t_diff();
		close_out();
	end
endmodule
`default_nettype wire
